// ==== verilog/bus_cycle_pkg.sv ====
// Constants and types shared by the external bus cycle engine
`default_nettype none
package bus_cycle_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int CS_W = 8;
  localparam int BE_W = 4;
  localparam int TT_W = 2;
  localparam int TM_W = 3;
  localparam int SIZ_W = 2;
  localparam int WAIT_W = 4;
  // Bus clock divider: half period in CLOCK cycles
  localparam int HALF_DIV = 2;
  localparam logic [1:0] HALF_DIV_M1 = 2'(HALF_DIV - 1);
  // Pin assignment select bits
  localparam int PIN_TT_BIT = 0;
  localparam int PIN_TM_BIT = 1;
  localparam int PIN_TIP_BIT = 2;
  localparam logic [2:0] PIN_ASSIGN_RESET = 3'h7;
  localparam logic [WAIT_W-1:0] WAIT_RESET = 4'h0;
  typedef enum {
    ST_IDLE,
    ST_S0,
    ST_S1,
    ST_S2,
    ST_S3,
    ST_S4,
    ST_S5
  } bus_state_t;
endpackage
`default_nettype wire

// ==== verilog/bus_req_if.sv ====
// Request and answer bundle between cycle engine and link side
`timescale 1ns/100ps
`default_nettype none
interface bus_req_if
  import bus_cycle_pkg::*;
  ();
  logic req_tgl;
  logic ack_tgl;
  logic write;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic [TT_W-1:0] ttype;
  logic [TM_W-1:0] tmod;
  logic [SIZ_W-1:0] tsize;
  logic [CS_W-1:0] cs_sel;
  logic [BE_W-1:0] be;
  logic int_term;
  logic [WAIT_W-1:0] wait_cnt;
  modport core (output req_tgl, write, addr, wdata, ttype, tmod, tsize, cs_sel, be,
    int_term, wait_cnt, input ack_tgl, rdata);
  modport link (input req_tgl, write, addr, wdata, ttype, tmod, tsize, cs_sel, be,
    int_term, wait_cnt, output ack_tgl, rdata);
endinterface
`default_nettype wire

// ==== verilog/bus_sync2.sv ====
// Two-flop level synchroniser
`timescale 1ns/100ps
`default_nettype none
module bus_sync2 (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic d,
  output logic q
);
  logic s1_q;
  logic s1_d;
  logic q_d;
  always_comb begin
    s1_d = d;
    q_d = s1_q;
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s1_q <= 1'b0;
      q <= 1'b0;
    end else begin
      s1_q <= s1_d;
      q <= q_d;
    end
  end
endmodule // bus_sync2
`default_nettype wire

// ==== verilog/bus_cycle_fsm.sv ====
// External bus cycle state machine, link side on bus clock
// What this block does
// RULE1 - Each bus clock splits into even high-phase and odd low-phase states.
// RULE2 - S0 rising edge drives address and read/write level, asserts progress.
// RULE3 - S0 rising edge asserts type, modifier, size and start for the cycle.
// RULE4 - Address strobe asserts on the S1 falling edge once attributes are stable.
// RULE5 - Chip select, byte lanes and output enable assert on that same edge.
// RULE6 - Fast termination: partner acknowledges in S1, data taken at next rising edge; here ta_s lags two edges, so an S1 acknowledge is taken in S2.
// RULE7 - Start negates entering S2; S2 and S3 are skipped when fast-terminated.
// RULE8 - Writes drive the data bus from the rising edge that starts S2.
// RULE9 - Whole-clock wait states are inserted in S3 until acknowledge is sampled.
// RULE10 - Read data is captured at the edge where acknowledge is seen asserted.
// RULE11 - The partner negates acknowledge during S4.
// RULE12 - The partner may release read data after S4 and stops before S5.
// RULE13 - The partner floats the data bus within two clocks of S4.
// RULE14 - Strobes, selects, lanes and output enable negate on the S5 falling edge.
// RULE15 - Edge ending S5 releases address, negates attributes and progress.
// RULE16 - Back-to-back cycles keep progress asserted across the S5 to S0 edge.
// RULE17 - Write data bus floats at the rising edge ending S5.
// RULE18 - Pin assignment bits choose whether type, modifier and progress are driven.
// RULE19 - Acknowledge timing is the same for internal and external termination; here internal termination never fast-terminates in S1.
// RULE20 - Internal termination generates acknowledge after a programmed wait count.
// RULE21 - After S5 go idle with strobes negated, or straight to S0.
`timescale 1ns/100ps
`default_nettype none
module bus_cycle_link
  import bus_cycle_pkg::*;
(
  input wire logic bclk,
  input wire logic rst_b,
  bus_req_if.link rq,
  input wire logic [2:0] pin_assign,
  input wire logic ta_in_n,
  input wire logic [DATA_W-1:0] data_in,
  output logic [ADDR_W-1:0] addr_o,
  output logic addr_oe,
  output logic rw_o,
  output logic ts_n,
  output logic tip_n,
  output logic [TT_W-1:0] tt_o,
  output logic [TM_W-1:0] tm_o,
  output logic [SIZ_W-1:0] siz_o,
  output logic [DATA_W-1:0] data_o,
  output logic data_oe,
  output logic as_n,
  output logic [CS_W-1:0] cs_n,
  output logic [BE_W-1:0] be_n,
  output logic oe_n
);
  // Rising-edge state; even states hold through the high phase
  bus_state_t st_q, st_d;
  logic req_s, req_seen_q, req_seen_d, ack_q, ack_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic [WAIT_W-1:0] wcnt_q, wcnt_d;
  logic ta_s, ta_int;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic aoe_q, aoe_d, rw_q, rw_d, ts_q, ts_d, tip_q, tip_d, doe_q, doe_d, wr_q, wr_d;
  logic [TT_W-1:0] tt_q, tt_d;
  logic [TM_W-1:0] tm_q, tm_d;
  logic [SIZ_W-1:0] siz_q, siz_d;
  logic [DATA_W-1:0] wd_q, wd_d;
  logic strobe_d, strobe_q;
  logic pend;

  bus_sync2 u_req (.clk(bclk), .rst_b(rst_b), .d(rq.req_tgl), .q(req_s));
  bus_sync2 u_ta (.clk(bclk), .rst_b(rst_b), .d(ta_in_n), .q(ta_s));

  assign pend = req_s != req_seen_q;
  // Internal termination acks only in S2 after the wait count, never on the S0/S1 fast-termination edge
  assign ta_int = rq.int_term && (wcnt_q == WAIT_RESET); // RULE19 RULE20

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d = st_q;
    req_seen_d = req_seen_q;
    ack_d = ack_q;
    rdata_d = rdata_q;
    wcnt_d = wcnt_q;
    addr_d = addr_q;
    aoe_d = aoe_q;
    rw_d = rw_q;
    ts_d = ts_q;
    tip_d = tip_q;
    doe_d = doe_q;
    wr_d = wr_q;
    tt_d = tt_q;
    tm_d = tm_q;
    siz_d = siz_q;
    wd_d = wd_q;
    strobe_d = strobe_q;
    case (st_q)
      ST_IDLE: begin
        if (pend) begin
          req_seen_d = req_s;
          st_d = ST_S0; // RULE21
          addr_d = rq.addr; // RULE2
          aoe_d = 1'b1;
          rw_d = ~rq.write;
          wr_d = rq.write;
          tip_d = 1'b0;
          ts_d = 1'b0; // RULE3
          tt_d = rq.ttype;
          tm_d = rq.tmod;
          siz_d = rq.tsize;
          wd_d = rq.wdata;
          wcnt_d = rq.wait_cnt;
          strobe_d = 1'b1; // RULE4 RULE5
        end
      end
      ST_S0: begin
        // Rising edge ending S0/S1: fast termination samples here
        ts_d = 1'b1; // RULE7
        doe_d = wr_q; // RULE8
        if (!ta_s && !rq.int_term) begin
          rdata_d = data_in; // RULE6
          // Strobes drop on the next falling edge, which is S5
          strobe_d = 1'b0; // RULE14
          st_d = ST_S4; // RULE7
        end else begin
          st_d = ST_S2;
        end
      end
      ST_S2: begin
        if (!ta_s || ta_int) begin
          rdata_d = data_in; // RULE10
          strobe_d = 1'b0; // RULE14
          st_d = ST_S4;
        end else begin
          if (wcnt_q != WAIT_RESET) begin
            wcnt_d = wcnt_q - 4'h1;
          end
          st_d = ST_S2; // RULE9
        end
      end
      ST_S4: begin
        // One register state covers S4 and S5; this edge ends S5
        doe_d = 1'b0; // RULE17
        ack_d = ~ack_q;
        if (pend) begin
          req_seen_d = req_s;
          st_d = ST_S0; // RULE16
          addr_d = rq.addr;
          rw_d = ~rq.write;
          wr_d = rq.write;
          ts_d = 1'b0;
          tt_d = rq.ttype;
          tm_d = rq.tmod;
          siz_d = rq.tsize;
          wd_d = rq.wdata;
          wcnt_d = rq.wait_cnt;
          strobe_d = 1'b1;
        end else begin
          st_d = ST_IDLE; // RULE21
          aoe_d = 1'b0; // RULE15
          tip_d = 1'b1;
          tt_d = '0;
          tm_d = '0;
          siz_d = '0;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge bclk) begin
    if (!rst_b) begin
      st_q <= ST_IDLE;
      req_seen_q <= 1'b0;
      ack_q <= 1'b0;
      rdata_q <= '0;
      wcnt_q <= WAIT_RESET;
      addr_q <= '0;
      aoe_q <= 1'b0;
      rw_q <= 1'b1;
      ts_q <= 1'b1;
      tip_q <= 1'b1;
      doe_q <= 1'b0;
      wr_q <= 1'b0;
      tt_q <= '0;
      tm_q <= '0;
      siz_q <= '0;
      wd_q <= '0;
      strobe_q <= 1'b0;
    end else begin
      st_q <= st_d;
      req_seen_q <= req_seen_d;
      ack_q <= ack_d;
      rdata_q <= rdata_d;
      wcnt_q <= wcnt_d;
      addr_q <= addr_d;
      aoe_q <= aoe_d;
      rw_q <= rw_d;
      ts_q <= ts_d;
      tip_q <= tip_d;
      doe_q <= doe_d;
      wr_q <= wr_d;
      tt_q <= tt_d;
      tm_q <= tm_d;
      siz_q <= siz_d;
      wd_q <= wd_d;
      strobe_q <= strobe_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Falling-edge strobes: assert in S1, negate in S5
  logic fstrobe_q;
  always_ff @(negedge bclk) begin
    if (!rst_b) begin
      fstrobe_q <= 1'b0;
    end else begin
      fstrobe_q <= strobe_q; // RULE1 RULE4 RULE14
    end
  end

  always_comb begin
    addr_o = addr_q;
    addr_oe = aoe_q;
    rw_o = rw_q;
    ts_n = ts_q;
    tip_n = pin_assign[PIN_TIP_BIT] ? tip_q : 1'b1; // RULE18
    tt_o = pin_assign[PIN_TT_BIT] ? tt_q : '0; // RULE18
    tm_o = pin_assign[PIN_TM_BIT] ? tm_q : '0;
    siz_o = siz_q;
    data_o = wd_q;
    data_oe = doe_q;
    as_n = ~fstrobe_q;
    cs_n = fstrobe_q ? ~rq.cs_sel : {CS_W{1'b1}}; // RULE5
    be_n = fstrobe_q ? ~rq.be : {BE_W{1'b1}};
    oe_n = ~(fstrobe_q && !wr_q);
    rq.ack_tgl = ack_q;
    rq.rdata = rdata_q;
  end
endmodule // bus_cycle_link

////////////////////////////////////////////////////////////////////
module bus_cycle_fsm
  import bus_cycle_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire logic CE,
  input wire logic BUS_CLK,
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire logic REQ_WRITE,
  input wire logic [ADDR_W-1:0] REQ_ADDR,
  input wire logic [DATA_W-1:0] REQ_WDATA,
  input wire logic [TT_W-1:0] REQ_TTYPE,
  input wire logic [TM_W-1:0] REQ_TMOD,
  input wire logic [SIZ_W-1:0] REQ_SIZE,
  input wire logic [CS_W-1:0] REQ_CS_SEL,
  input wire logic [BE_W-1:0] REQ_BE,
  input wire logic REQ_INT_TERM,
  input wire logic [WAIT_W-1:0] REQ_WAITS,
  output logic DONE,
  output logic [DATA_W-1:0] RDATA,
  input wire logic [2:0] PIN_ASSIGN,
  input wire logic TRANSFER_ACK_N,
  input wire logic [DATA_W-1:0] DATA_IN,
  output logic [ADDR_W-1:0] ADDR_OUT,
  output logic ADDR_OE,
  output logic READ_NOT_WRITE,
  output logic TRANSFER_START_N,
  output logic TRANSFER_IN_PROGRESS_N,
  output logic [TT_W-1:0] TRANSFER_TYPE,
  output logic [TM_W-1:0] TRANSFER_MODIFIER,
  output logic [SIZ_W-1:0] TRANSFER_SIZE,
  output logic [DATA_W-1:0] DATA_OUT,
  output logic DATA_OE,
  output logic ADDR_STROBE_N,
  output logic [CS_W-1:0] CHIP_SELECT_N,
  output logic [BE_W-1:0] BYTE_LANE_ENABLE_N,
  output logic OUT_ENABLE_N
);
  bus_req_if rq ();
  logic busy_q, busy_d, req_q, req_d, ack_s, ack_seen_q, ack_seen_d, done_q, done_d;
  logic [DATA_W-1:0] rd_q, rd_d;
  logic [ADDR_W-1:0] a_q, a_d;
  logic [DATA_W-1:0] w_q, w_d;
  logic [TT_W-1:0] t_q, t_d;
  logic [TM_W-1:0] m_q, m_d;
  logic [SIZ_W-1:0] s_q, s_d;
  logic [CS_W-1:0] c_q, c_d;
  logic [BE_W-1:0] b_q, b_d;
  logic [WAIT_W-1:0] n_q, n_d;
  logic wr_q, wr_d, it_q, it_d;

  bus_sync2 u_ack (.clk(CLOCK), .rst_b(RST_B), .d(rq.ack_tgl), .q(ack_s));

  // Held stable while busy so the link sees settled words
  always_comb begin
    busy_d = busy_q;
    req_d = req_q;
    ack_seen_d = ack_seen_q;
    done_d = 1'b0;
    rd_d = rd_q;
    a_d = a_q;
    w_d = w_q;
    t_d = t_q;
    m_d = m_q;
    s_d = s_q;
    c_d = c_q;
    b_d = b_q;
    n_d = n_q;
    wr_d = wr_q;
    it_d = it_q;
    if (busy_q && ack_s != ack_seen_q) begin
      ack_seen_d = ack_s;
      busy_d = 1'b0;
      done_d = 1'b1;
      rd_d = rq.rdata;
    end else if (!busy_q && REQ_VALID) begin
      busy_d = 1'b1;
      req_d = ~req_q;
      a_d = REQ_ADDR;
      w_d = REQ_WDATA;
      t_d = REQ_TTYPE;
      m_d = REQ_TMOD;
      s_d = REQ_SIZE;
      c_d = REQ_CS_SEL;
      b_d = REQ_BE;
      n_d = REQ_WAITS;
      wr_d = REQ_WRITE;
      it_d = REQ_INT_TERM;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      busy_q <= 1'b0;
      req_q <= 1'b0;
      ack_seen_q <= 1'b0;
      done_q <= 1'b0;
      rd_q <= '0;
      a_q <= '0;
      w_q <= '0;
      t_q <= '0;
      m_q <= '0;
      s_q <= '0;
      c_q <= '0;
      b_q <= '0;
      n_q <= WAIT_RESET;
      wr_q <= 1'b0;
      it_q <= 1'b0;
    end else if (CE) begin
      busy_q <= busy_d;
      req_q <= req_d;
      ack_seen_q <= ack_seen_d;
      done_q <= done_d;
      rd_q <= rd_d;
      a_q <= a_d;
      w_q <= w_d;
      t_q <= t_d;
      m_q <= m_d;
      s_q <= s_d;
      c_q <= c_d;
      b_q <= b_d;
      n_q <= n_d;
      wr_q <= wr_d;
      it_q <= it_d;
    end
  end

  always_comb begin
    rq.req_tgl = req_q;
    rq.write = wr_q;
    rq.addr = a_q;
    rq.wdata = w_q;
    rq.ttype = t_q;
    rq.tmod = m_q;
    rq.tsize = s_q;
    rq.cs_sel = c_q;
    rq.be = b_q;
    rq.int_term = it_q;
    rq.wait_cnt = n_q;
    REQ_READY = !busy_q && CE;
    DONE = done_q;
    RDATA = rd_q;
  end

  bus_cycle_link u_link (
    .bclk(BUS_CLK),
    .rst_b(RST_B),
    .rq(rq.link),
    .pin_assign(PIN_ASSIGN),
    .ta_in_n(TRANSFER_ACK_N),
    .data_in(DATA_IN),
    .addr_o(ADDR_OUT),
    .addr_oe(ADDR_OE),
    .rw_o(READ_NOT_WRITE),
    .ts_n(TRANSFER_START_N),
    .tip_n(TRANSFER_IN_PROGRESS_N),
    .tt_o(TRANSFER_TYPE),
    .tm_o(TRANSFER_MODIFIER),
    .siz_o(TRANSFER_SIZE),
    .data_o(DATA_OUT),
    .data_oe(DATA_OE),
    .as_n(ADDR_STROBE_N),
    .cs_n(CHIP_SELECT_N),
    .be_n(BYTE_LANE_ENABLE_N),
    .oe_n(OUT_ENABLE_N)
  );
endmodule // bus_cycle_fsm
`default_nettype wire

// ==== tb/bus_cycle_fsm_chk.sv ====
// Pin timing assertions for the bus cycle engine
`timescale 1ns/100ps
`default_nettype none
module bus_cycle_fsm_chk
  import bus_cycle_pkg::*;
(
  input wire logic BUS_CLK,
  input wire logic RST_B,
  input wire logic [2:0] PIN_ASSIGN,
  input wire logic TRANSFER_START_N,
  input wire logic TRANSFER_IN_PROGRESS_N,
  input wire logic ADDR_OE,
  input wire logic READ_NOT_WRITE,
  input wire logic DATA_OE,
  input wire logic ADDR_STROBE_N,
  input wire logic [CS_W-1:0] CHIP_SELECT_N,
  input wire logic [BE_W-1:0] BYTE_LANE_ENABLE_N,
  input wire logic OUT_ENABLE_N
);
  default clocking cb @(posedge BUS_CLK); endclocking
  default disable iff (!RST_B);
  property p_ts_one; $fell(TRANSFER_START_N) |=> TRANSFER_START_N; endproperty
  a_ts_one: assert property (p_ts_one) else $error("start strobe wider than one clock");
  property p_s0; $fell(TRANSFER_START_N) |-> ADDR_OE && !(PIN_ASSIGN[2] && TRANSFER_IN_PROGRESS_N);
  endproperty
  a_s0: assert property (p_s0) else $error("address or progress missing in S0");
  property p_s1; $fell(TRANSFER_START_N) |-> !ADDR_STROBE_N && CHIP_SELECT_N != '1; endproperty
  a_s1: assert property (p_s1) else $error("strobes not low after S1");
  property p_win; ADDR_STROBE_N |-> &CHIP_SELECT_N && &BYTE_LANE_ENABLE_N && OUT_ENABLE_N;
  endproperty
  a_win: assert property (p_win) else $error("select outside strobe window");
  property p_end;
    $rose(ADDR_STROBE_N) |=> !TRANSFER_START_N || (TRANSFER_IN_PROGRESS_N && !ADDR_OE);
  endproperty
  a_end: assert property (p_end) else $error("cycle end not clean");
  property p_rel; $rose(ADDR_STROBE_N) |=> !DATA_OE; endproperty
  a_rel: assert property (p_rel) else $error("write data still driven");
  property p_wdrv; DATA_OE |-> !READ_NOT_WRITE && ADDR_OE; endproperty
  a_wdrv: assert property (p_wdrv) else $error("data driven outside write");
  property p_wait; $fell(TRANSFER_START_N) |-> ##[1:40] $rose(ADDR_STROBE_N); endproperty
  a_wait: assert property (p_wait) else $error("cycle never terminated");
  property p_tip; !PIN_ASSIGN[2] && !$past(PIN_ASSIGN[2]) |-> TRANSFER_IN_PROGRESS_N; endproperty
  a_tip: assert property (p_tip) else $error("progress pin driven while unselected");
  c_rd: cover property ($fell(TRANSFER_START_N) && READ_NOT_WRITE);
  c_wr: cover property (DATA_OE);
  c_off: cover property ($fell(TRANSFER_START_N) && !PIN_ASSIGN[2]);
endmodule // bus_cycle_fsm_chk
bind bus_cycle_fsm bus_cycle_fsm_chk u_bus_cycle_fsm_chk (.BUS_CLK, .RST_B, .PIN_ASSIGN,
  .TRANSFER_START_N, .TRANSFER_IN_PROGRESS_N, .ADDR_OE, .READ_NOT_WRITE, .DATA_OE,
  .ADDR_STROBE_N, .CHIP_SELECT_N, .BYTE_LANE_ENABLE_N, .OUT_ENABLE_N);
`default_nettype wire

// ==== tb/bus_ext_mem.sv ====
// Memory model on the far side of the bus
`timescale 1ns/100ps
`default_nettype none
module bus_ext_mem
  import bus_cycle_pkg::*;
(
  input wire logic bclk,
  input wire logic ext_term,
  input wire logic [1:0] ack_dly,
  input wire logic ts_n,
  input wire logic as_n,
  input wire logic rw,
  input wire logic data_oe,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  output logic ta_n,
  output logic [DATA_W-1:0] rdata
);
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [DATA_W-1:0] word;
  int cnt = 0;
  initial ta_n = 1'b1;
  // One clock acknowledge, negated again by S4
  always @(posedge bclk) begin
    ta_n <= (cnt != 1);
    if (cnt != 0) cnt <= cnt - 1;
    if (!ts_n && ext_term) cnt <= int'(ack_dly) + 1;
  end
  // Store at strobe release so internally terminated writes land too
  always @(posedge as_n) begin
    if (!rw && data_oe) mem[addr] = wdata;
  end
  // Looked up one clock after the address; fast termination would be too early
  always @(posedge bclk) word <= mem.exists(addr) ? mem[addr] : ~addr;
  // Released bus shows inverted data so a late capture is seen
  assign rdata = (!as_n && rw) ? word : ~word;
endmodule // bus_ext_mem
`default_nettype wire

// ==== tb/bus_cycle_fsm_tb.sv ====
// Self-checking bench for the bus cycle engine
`timescale 1ns/100ps
`default_nettype none
module bus_cycle_fsm_tb;
  import bus_cycle_pkg::*;
  logic clock = 1'b0, bus_clk = 1'b0, rst_b = 1'b0, ce = 1'b1, req_valid = 1'b0;
  logic req_write = 1'b0, req_int = 1'b0, ext_term = 1'b1, req_ready, done, ta_n, addr_oe;
  logic rnw, ts_n, tip_n, data_oe, as_n, oe_n;
  logic [ADDR_W-1:0] req_addr = '0, addr_out;
  logic [DATA_W-1:0] req_wdata = '0, rdata, data_in, data_out;
  logic [TT_W-1:0] req_ttype = '0, tt;
  logic [TM_W-1:0] req_tmod = '0, tm;
  logic [SIZ_W-1:0] req_size = '0, siz;
  logic [CS_W-1:0] req_cs = 8'h01, cs_n;
  logic [BE_W-1:0] req_be = '0, be_n;
  logic [WAIT_W-1:0] req_waits = '0;
  logic [2:0] pin_assign = 3'h7;
  logic [1:0] ack_dly = 2'h0;
  logic [DATA_W-1:0] model [logic [ADDR_W-1:0]];
  int failures = 0, samples_checked = 0, seed = 31561, cycles = 0;
  always #10 clock = ~clock;
  always #62.5 bus_clk = ~bus_clk;
  bus_cycle_fsm u_bus_cycle_fsm (.CLOCK(clock), .RST_B(rst_b), .CE(ce), .BUS_CLK(bus_clk),
    .REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ_WRITE(req_write), .REQ_ADDR(req_addr),
    .REQ_WDATA(req_wdata), .REQ_TTYPE(req_ttype), .REQ_TMOD(req_tmod), .REQ_SIZE(req_size),
    .REQ_CS_SEL(req_cs), .REQ_BE(req_be), .REQ_INT_TERM(req_int), .REQ_WAITS(req_waits),
    .DONE(done), .RDATA(rdata), .PIN_ASSIGN(pin_assign), .TRANSFER_ACK_N(ta_n),
    .DATA_IN(data_in), .ADDR_OUT(addr_out), .ADDR_OE(addr_oe), .READ_NOT_WRITE(rnw),
    .TRANSFER_START_N(ts_n), .TRANSFER_IN_PROGRESS_N(tip_n), .TRANSFER_TYPE(tt),
    .TRANSFER_MODIFIER(tm), .TRANSFER_SIZE(siz), .DATA_OUT(data_out), .DATA_OE(data_oe),
    .ADDR_STROBE_N(as_n), .CHIP_SELECT_N(cs_n), .BYTE_LANE_ENABLE_N(be_n), .OUT_ENABLE_N(oe_n));
  bus_ext_mem u_bus_ext_mem (.bclk(bus_clk), .ext_term(ext_term), .ack_dly(ack_dly),
    .ts_n(ts_n), .as_n(as_n), .rw(rnw), .data_oe(data_oe), .addr(addr_out),
    .wdata(data_out), .ta_n(ta_n), .rdata(data_in));
  task automatic check_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    if (failures == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Attributes and strobes as they stand at the edge that ends S0 and S1
  always @(posedge bus_clk) begin
    logic [8:0] exp_attr;
    logic [13:0] exp_strb;
    exp_attr = {~pin_assign[2], ~req_write, req_ttype & {TT_W{pin_assign[0]}},
      req_tmod & {TM_W{pin_assign[1]}}, req_size};
    exp_strb = {1'b0, ~req_cs, ~req_be, req_write};
    if (rst_b && ts_n === 1'b0) begin
      check_word(addr_out, req_addr);
      check_word(32'({tip_n, rnw, tt, tm, siz}), 32'(exp_attr));
      check_word(32'({as_n, cs_n, be_n, oe_n}), 32'(exp_strb));
    end
  end
  // Internal termination never mixed with external acknowledge
  task automatic bus_op(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n = 0;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    req_ttype = TT_W'($random(seed));
    req_tmod = TM_W'($random(seed));
    req_size = SIZ_W'($random(seed));
    req_be = BE_W'($random(seed));
    req_cs = CS_W'(1) << (3'($random(seed)));
    req_int = 1'($random(seed));
    ext_term = !req_int;
    req_waits = WAIT_W'(2'($random(seed)));
    ack_dly = 2'($random(seed));
    req_valid = 1'b1;
    // Ready is settled one step after an edge and stands until the next
    while (req_ready !== 1'b1) begin
      @(posedge clock);
      #1;
    end
    @(posedge clock);
    #1 req_valid = 1'b0;
    while (done !== 1'b1 && n < 3000) begin
      @(posedge clock);
      #1 n++;
    end
    if (n >= 3000) failures++;
    if (!w) check_word(rdata, model.exists(a) ? model[a] : ~a);
    else model[a] = d;
  endtask
  initial begin
    logic [ADDR_W-1:0] a;
    repeat (12) @(posedge clock);
    repeat (3) @(posedge bus_clk);
    @(posedge clock);
    #1 rst_b = 1'b1;
    ce = 1'b0;
    req_valid = 1'b1;
    @(posedge clock);
    #1 check_word({31'h0, req_ready}, 32'h0);
    req_valid = 1'b0;
    ce = 1'b1;
    for (int i = 0; i < 24; i++) begin
      pin_assign = 3'($random(seed));
      a = ADDR_W'($random(seed)) & ~32'h3;
      bus_op(1'b1, a, DATA_W'($random(seed)));
      bus_op(1'b0, a, '0);
      bus_op(1'b0, ~a, '0);
    end
    close_out();
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      close_out();
    end
  end
endmodule // bus_cycle_fsm_tb
`default_nettype wire
